// >>> design/dasw_pkg.sv
// Purpose: Shared constants and types of the dead-band and shutdown waveform block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Override level of an output is bit 0 of its two-bit field
package dasw_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DBF  = 8'h04;
    localparam logic [7:0] OFS_CLK  = 8'h08;
    localparam logic [7:0] OFS_SD   = 8'h0c;
    localparam logic [7:0] OFS_SRC  = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // Field positions
    localparam int CTRL_EN_BIT  = 7;
    localparam int CTRL_LD_BIT  = 6;
    localparam int CLK_CS_BIT   = 0;
    localparam int SD_SHUT_BIT  = 7;
    localparam int SD_REN_BIT   = 6;
    localparam int SD_LSBD_LSB  = 4;
    localparam int SD_LSAC_LSB  = 2;
    localparam int STAT_IN_BIT  = 0;
    localparam int STAT_IRQ_BIT = 1;
    localparam int DBF_W        = 6;
    localparam int SRC_W        = 6;
    // Reset values
    localparam logic [2:0]       MODE_RST = 3'h0;
    localparam logic [DBF_W-1:0] DBF_RST  = 6'h00;
    localparam logic [SRC_W-1:0] SRC_RST  = 6'h00;
    localparam logic [1:0]       LVL_RST  = 2'h0;
    // Waveform clock: system clock or divided-down internal fast oscillator
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned OSC_PERIOD_NS = 60;
    localparam int unsigned OSC_DIV_INT   = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  OSC_DIV       = 8'(OSC_DIV_INT);

    typedef enum logic [2:0] {
        MODE_ASYNC_STEER = 3'b000,
        MODE_SYNC_STEER  = 3'b001,
        MODE_FWD_FULL    = 3'b010,
        MODE_REV_FULL    = 3'b011,
        MODE_HALF        = 3'b100,
        MODE_PUSH_PULL   = 3'b101
    } dasw_mode_type;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_FALL = 2'b01,
        LD_RISE = 2'b11
    } dasw_ld_type;

    typedef struct packed {
        logic out_a;
        logic out_b;
        logic out_c;
        logic out_d;
    } dasw_out_type;
endpackage : dasw_pkg

// >>> design/dasw_core.sv
// Purpose: Falling/forward dead band, dead-band buffering and auto-shutdown of a waveform generator
// Assumes: pclk 100 MHz, APB slave, data and fault pins asynchronous
// Notes:   Fault override bypasses the synchronisers so a fault acts at once
//
// Operation
// [R1] Half-bridge: B turns on after falling dead band
// [R2] Full-bridge: forward delay on reverse-to-forward, D only
// [R3] Falling count sets delay in waveform clocks
// [R4] Timing starts on input edge; zero gives none
// [R5] Input reversal during count suppresses the pulse
// [R6] Disabled: count write updates active value
// [R7] Enabled: load at rise after fall after request
// [R8] Asynchronous input gives one clock of jitter
// [R9] Software shutdown bit holds shutdown without restart
// [R10] Shutdown bit shows condition; set/cleared by both
// [R11] Enabled fault forces override levels immediately
// [R12] Six active-low fault sources, each enabled separately
// [R13] Fault is level sensitive; blocks clearing
// [R14] Two-bit override fields for B/D and A/C
// [R15] Every shutdown event sets the interrupt flag; code sets it only on entry to shutdown
// [R16] No restart while a source remains
// [R17] Software clears shutdown; resume at data rise
// [R18] Auto-restart clears shutdown; resume at data rise
// [R19] Software clear ignored while condition present
// [R20] Fast oscillator kept on in sleep when used
// [R21] Software configures while disabled, enables last
// [R22] Enabling starts in shutdown state
// [R23] Mode field selects six modes, two reserved
// [R24] Load request only after enable; hardware clears
// [R25] Shutdown overrides pending dead band or steering
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module dasw_core
    import dasw_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               data_in,
    input  wire logic [SRC_W-1:0]   fault_n,
    output dasw_out_type            wave_out,
    output logic                    osc_keep_alive,
    output logic                    shutdown_irq_flag
);
    logic                 en_ff;
    dasw_mode_type        mode_ff;
    dasw_ld_type          ld_st_ff;
    logic [DBF_W-1:0]     dbf_buf_ff;
    logic [DBF_W-1:0]     dbf_act_ff;
    logic                 cs_ff;
    logic                 sd_ff;
    logic                 ren_ff;
    logic [1:0]           lvl_bd_ff;
    logic [1:0]           lvl_ac_ff;
    logic [SRC_W-1:0]     src_en_ff;
    logic                 irq_ff;
    logic [31:0]          prdata_ff;
    logic [7:0]           osc_cnt_ff;
    logic                 data_s1_ff;
    logic                 data_s2_ff;
    logic                 data_s3_ff;
    logic [SRC_W-1:0]     fault_s1_ff;
    logic [SRC_W-1:0]     fault_s2_ff;
    logic                 run_ff;
    logic                 db_busy_ff;
    logic [DBF_W-1:0]     db_cnt_ff;
    logic                 b_on_ff;
    logic                 d_gate_ff;
    logic                 fwd_ff;
    logic                 pp_ff;
    dasw_out_type         nom_ff;
    dasw_out_type         nxt_nom;
    dasw_out_type         ovr_lvl;
    logic                 nxt_sd;
    logic                 nxt_irq;

    function automatic logic is_full(input dasw_mode_type m);
        return (m == MODE_FWD_FULL) || (m == MODE_REV_FULL);
    endfunction

    // Bus decode
    logic wr;
    logic rd_setup;
    logic mapped;
    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped   = (paddr == OFS_CTRL) || (paddr == OFS_DBF) || (paddr == OFS_CLK) ||
                      (paddr == OFS_SD) || (paddr == OFS_SRC) || (paddr == OFS_STAT);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_ff;

    logic wr_ctrl;
    logic wr_dbf;
    logic wr_sd;
    assign wr_ctrl = wr && (paddr == OFS_CTRL);
    assign wr_dbf  = wr && (paddr == OFS_DBF);
    assign wr_sd   = wr && (paddr == OFS_SD);

    // Synchronisers; stage 1 feeds only stage 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_s1_ff  <= 1'b0;
            data_s2_ff  <= 1'b0;
            data_s3_ff  <= 1'b0;
            fault_s1_ff <= '1;
            fault_s2_ff <= '1;
        end else begin
            data_s1_ff  <= data_in;
            data_s2_ff  <= data_s1_ff;
            data_s3_ff  <= data_s2_ff;
            fault_s1_ff <= fault_n;
            fault_s2_ff <= fault_s1_ff;
        end
    end

    logic data_rise;
    logic data_fall;
    logic fault_s_any;
    logic fault_raw;
    assign data_rise   = data_s2_ff && !data_s3_ff;
    assign data_fall   = !data_s2_ff && data_s3_ff;
    // [R12] Active-low sources
    // [R13] Level, not edge
    assign fault_s_any = |(~fault_s2_ff & src_en_ff);
    // Raw path on purpose: the override must not wait for the synchroniser
    assign fault_raw   = |(~fault_n & src_en_ff);

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff      <= 1'b0;
            mode_ff    <= MODE_ASYNC_STEER;
            cs_ff      <= 1'b0;
            ren_ff     <= 1'b0;
            lvl_bd_ff  <= LVL_RST;
            lvl_ac_ff  <= LVL_RST;
            src_en_ff  <= SRC_RST;
            dbf_buf_ff <= DBF_RST;
        end else if (wr) begin
            unique case (paddr)
                OFS_CTRL: begin
                    en_ff   <= pwdata[CTRL_EN_BIT];
                    mode_ff <= dasw_mode_type'(pwdata[2:0]);
                end
                OFS_DBF: dbf_buf_ff <= pwdata[DBF_W-1:0];
                OFS_CLK: cs_ff <= pwdata[CLK_CS_BIT];
                OFS_SD: begin
                    ren_ff    <= pwdata[SD_REN_BIT];
                    lvl_bd_ff <= pwdata[SD_LSBD_LSB +: 2];
                    lvl_ac_ff <= pwdata[SD_LSAC_LSB +: 2];
                end
                OFS_SRC: src_en_ff <= pwdata[SRC_W-1:0];
                default: ;
            endcase
        end
    end

    // [R24] Request accepted only once already enabled
    // [R7] Fall then rise, then load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_st_ff <= LD_IDLE;
        end else if (!en_ff) begin
            ld_st_ff <= LD_IDLE;
        end else begin
            unique case (ld_st_ff)
                LD_IDLE: if (wr_ctrl && pwdata[CTRL_LD_BIT]) ld_st_ff <= LD_FALL;
                LD_FALL: if (data_fall) ld_st_ff <= LD_RISE;
                LD_RISE: if (data_rise) ld_st_ff <= LD_IDLE;
                default: ld_st_ff <= LD_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbf_act_ff <= DBF_RST;
        end else if (!en_ff && wr_dbf) begin
            // [R6] Straight through while disabled
            dbf_act_ff <= pwdata[DBF_W-1:0];
        end else if (en_ff && ld_st_ff == LD_RISE && data_rise) begin
            dbf_act_ff <= dbf_buf_ff;
        end
    end

    // [R20] Oscillator request
    assign osc_keep_alive = en_ff && cs_ff;

    // Waveform clock enable; [R8] async edges land anywhere in a tick
    logic wave_tick;
    logic db_start;
    assign wave_tick = !cs_ff || (osc_cnt_ff == OSC_DIV - 8'h01);
    // Divider restarts with the count so n ticks span n full periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_ff <= 8'h00;
        end else if (!cs_ff || wave_tick || db_start) begin
            osc_cnt_ff <= 8'h00;
        end else begin
            osc_cnt_ff <= osc_cnt_ff + 8'h01;
        end
    end

    // Shutdown state
    logic set_any;
    logic clr_ok;
    assign set_any = (wr_sd && pwdata[SD_SHUT_BIT]) || (en_ff && fault_s_any) ||
                     (wr_ctrl && pwdata[CTRL_EN_BIT] && !en_ff);
    // [R16] All sources gone first
    assign clr_ok  = !fault_s_any;
    always_comb begin
        nxt_sd = sd_ff;
        // [R19] Clear only with no condition
        if (clr_ok && ((wr_sd && !pwdata[SD_SHUT_BIT]) || (ren_ff && en_ff))) begin
            nxt_sd = 1'b0;
        end
        // [R9] [R10] [R22] Set beats clear
        if (set_any) begin
            nxt_sd = 1'b1;
        end
        // [R15] Flag on each entry; set beats clear
        nxt_irq = irq_ff;
        if (wr && paddr == OFS_STAT && pwdata[STAT_IRQ_BIT]) begin
            nxt_irq = 1'b0;
        end
        if (set_any && !sd_ff) begin
            nxt_irq = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_ff  <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            sd_ff  <= nxt_sd;
            irq_ff <= nxt_irq;
        end
    end
    assign shutdown_irq_flag = irq_ff;

    // [R17] [R18] Resume at first data rise after clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 1'b0;
        end else if (!en_ff || sd_ff) begin
            run_ff <= 1'b0;
        end else if (data_rise) begin
            run_ff <= 1'b1;
        end
    end

    // Dead-band counter shared by half-bridge fall and forward turn
    logic db_done;
    logic db_cancel;
    logic dir_turn_fwd;
    assign dir_turn_fwd = is_full(mode_ff) && data_rise && !fwd_ff && (mode_ff == MODE_FWD_FULL);
    // [R4] Started by an input edge, never by a zero count
    assign db_start  = (dbf_act_ff != DBF_RST) &&
                       (((mode_ff == MODE_HALF) && data_fall) || dir_turn_fwd);
    // [R5] Input reversed before the end
    assign db_cancel = db_busy_ff && (((mode_ff == MODE_HALF) && data_rise) ||
                                      (is_full(mode_ff) && data_fall));
    // [R3] Done after the programmed number of ticks
    assign db_done   = db_busy_ff && !db_cancel && wave_tick && (db_cnt_ff + 6'h01 == dbf_act_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_busy_ff <= 1'b0;
            db_cnt_ff  <= 6'h00;
        end else if (db_start) begin
            db_busy_ff <= 1'b1;
            db_cnt_ff  <= 6'h00;
        end else if (db_cancel || db_done || !en_ff) begin
            db_busy_ff <= 1'b0;
        end else if (db_busy_ff && wave_tick) begin
            db_cnt_ff  <= db_cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_on_ff <= 1'b0;
        end else if (data_rise || !en_ff) begin
            b_on_ff <= 1'b0;
        // [R1] B on after the fall delay
        end else if ((data_fall && dbf_act_ff == DBF_RST) || (db_done && mode_ff == MODE_HALF)) begin
            b_on_ff <= 1'b1;
        end
    end

    // [R2] Direction latched on a rising edge; D waits on forward turn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_ff    <= 1'b1;
            d_gate_ff <= 1'b1;
            pp_ff     <= 1'b0;
        end else begin
            if (is_full(mode_ff) && data_rise) begin
                fwd_ff <= (mode_ff == MODE_FWD_FULL);
            end
            if (db_start && dir_turn_fwd) begin
                d_gate_ff <= 1'b0;
            end else if (db_done || db_cancel || !db_busy_ff) begin
                d_gate_ff <= 1'b1;
            end
            if (data_rise) begin
                pp_ff <= !pp_ff;
            end
        end
    end

    // [R23] Mode decode; reserved codes drive all low
    always_comb begin
        nxt_nom = '0;
        unique case (mode_ff)
            MODE_ASYNC_STEER, MODE_SYNC_STEER: nxt_nom = {4{data_s2_ff}};
            MODE_FWD_FULL, MODE_REV_FULL: begin
                nxt_nom.out_a = fwd_ff;
                nxt_nom.out_b = !fwd_ff && data_s2_ff;
                nxt_nom.out_c = !fwd_ff;
                nxt_nom.out_d = fwd_ff && data_s2_ff && d_gate_ff;
            end
            MODE_HALF: begin
                nxt_nom.out_a = data_s2_ff;
                nxt_nom.out_b = b_on_ff;
                nxt_nom.out_c = data_s2_ff;
                nxt_nom.out_d = b_on_ff;
            end
            MODE_PUSH_PULL: begin
                nxt_nom.out_a = data_s2_ff && pp_ff;
                nxt_nom.out_b = data_s2_ff && !pp_ff;
            end
            default: nxt_nom = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nom_ff <= '0;
        end else begin
            nom_ff <= nxt_nom;
        end
    end

    // [R14] Override levels per output pair
    assign ovr_lvl = '{out_a: lvl_ac_ff[0], out_b: lvl_bd_ff[0], out_c: lvl_ac_ff[0], out_d: lvl_bd_ff[0]};

    logic override;
    // [R11] [R25] Fault or shutdown wins, unclocked on the fault path
    assign override = en_ff && (sd_ff || fault_raw || !run_ff);
    assign wave_out = !en_ff ? '0 : (override ? ovr_lvl : nom_ff);

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= 32'h0000_0000;
            unique case (paddr)
                OFS_CTRL: prdata_ff[7:0] <= {en_ff, ld_st_ff != LD_IDLE, 3'h0, mode_ff};
                OFS_DBF:  prdata_ff[DBF_W-1:0] <= dbf_buf_ff;
                OFS_CLK:  prdata_ff[CLK_CS_BIT] <= cs_ff;
                OFS_SD:   prdata_ff[7:0] <= {sd_ff, ren_ff, lvl_bd_ff, lvl_ac_ff, 2'h0};
                OFS_SRC:  prdata_ff[SRC_W-1:0] <= src_en_ff;
                OFS_STAT: prdata_ff[1:0] <= {irq_ff, data_s2_ff};
                default:  prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_disabled_dbf_write;
        !en_ff && wr_dbf;
    endsequence
    sequence s_rise_after_fall;
        ld_st_ff == LD_RISE && data_rise && en_ff;
    endsequence

    property p_enable_shutdown;
        wr_ctrl && pwdata[CTRL_EN_BIT] && !en_ff |=> en_ff && sd_ff;
    endproperty
    a_enable_shutdown: assert property (p_enable_shutdown) else $error("no shutdown after enable"); // [R22]

    property p_clear_blocked;
        sd_ff && fault_s_any && en_ff |=> sd_ff;
    endproperty
    a_clear_blocked: assert property (p_clear_blocked) else $error("shutdown cleared under fault"); // [R19]

    property p_fault_override;
        en_ff && fault_raw |-> wave_out == ovr_lvl;
    endproperty
    a_fault_override: assert property (p_fault_override) else $error("fault did not override"); // [R11]

    property p_irq_on_entry;
        $rose(sd_ff) |-> irq_ff;
    endproperty
    a_irq_on_entry: assert property (p_irq_on_entry) else $error("flag missing on shutdown"); // [R15]

    property p_auto_restart;
        sd_ff && ren_ff && en_ff && !fault_s_any && !set_any |=> !sd_ff ##1 (!run_ff || $past(data_rise));
    endproperty
    a_auto_restart: assert property (p_auto_restart) else $error("auto-restart failed"); // [R18]

    property p_resume_on_rise;
        $rose(run_ff) |-> $past(data_rise) && !$past(sd_ff);
    endproperty
    a_resume_on_rise: assert property (p_resume_on_rise) else $error("resume not on data rise"); // [R17]

    property p_suppress;
        mode_ff == MODE_HALF && db_busy_ff && data_rise |=> !db_busy_ff && !b_on_ff;
    endproperty
    a_suppress: assert property (p_suppress) else $error("short pulse not suppressed"); // [R5]

    property p_buffer_load;
        s_rise_after_fall |=> dbf_act_ff == $past(dbf_buf_ff) && ld_st_ff == LD_IDLE;
    endproperty
    a_buffer_load: assert property (p_buffer_load) else $error("buffer not loaded"); // [R7]

    property p_disabled_load;
        s_disabled_dbf_write |=> dbf_act_ff == $past(pwdata[DBF_W-1:0]);
    endproperty
    a_disabled_load: assert property (p_disabled_load) else $error("disabled write not live"); // [R6]

    property p_zero_deadband;
        mode_ff == MODE_HALF && en_ff && data_fall && dbf_act_ff == DBF_RST |=> b_on_ff;
    endproperty
    a_zero_deadband: assert property (p_zero_deadband) else $error("zero count delayed B"); // [R4]
endmodule // dasw_core

// >>> bench/dasw_partner.sv
// Purpose: Bridge driver model that reports faults on a pin
// Assumes: Fault pin active low, pulled high while healthy
// Notes:   Trip request comes from the bench; reacts without a clock
`timescale 1ns/1ps
module dasw_partner
    import dasw_pkg::*;
(
    input  wire logic trip,
    output logic      fault_pin_n
);
    assign fault_pin_n = ~trip;
endmodule // dasw_partner

// >>> bench/dasw_core_tb_top.sv
// Purpose: Self-checking bench of the dead-band and shutdown block
// Assumes: Zero-wait APB slave, override level is bit 0 of each field
// Notes:   Dead-band windows allow sync latency plus one tick of jitter
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
module dasw_core_tb_top
    import dasw_pkg::*;
();
    logic             pclk, presetn, psel, penable, pwrite, data_in, trip, pin_n, sb;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rq;
    logic             pready, pslverr, re, osc_keep_alive, shutdown_irq_flag;
    logic [SRC_W-1:1] flt;
    logic [SRC_W-1:0] fault_n;
    dasw_out_type     wave_out;
    int               fail_count, cmp_count, k2;
    int               dl[$];
    assign fault_n = {flt, pin_n};

    dasw_core dasw_core_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .data_in, .fault_n, .wave_out, .osc_keep_alive, .shutdown_irq_flag);
    dasw_partner dasw_partner_i (.trip(trip), .fault_pin_n(pin_n));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // Hold the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin fail_count++; summarize(); end
        rq = prdata; re = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic fset(input int i, input logic v);
        if (i == 0) trip <= ~v;
        else flt[i] <= v;
    endtask

    task automatic rise();
        data_in <= 1'b0;
        cyc(6);
        data_in <= 1'b1;
        cyc(8);
    endtask

    function automatic logic in_win(input int k, input int d, input int t);
        return k >= d * t + 2 && k <= d * t + t + 4;
    endfunction

    // Disabled config, enable last, then software restart
    task automatic setup(input logic [5:0] d, input logic cs, input logic [2:0] md);
        wr(OFS_CTRL, 8'h00); wr(OFS_DBF, {2'h0, d}); wr(OFS_CLK, {7'h0, cs});
        wr(OFS_SD, 8'h10); wr(OFS_SRC, 8'h00); wr(OFS_STAT, 8'h02);
        wr(OFS_CTRL, {5'h18, md});
        rd(OFS_CTRL); `CHK(rq[CTRL_LD_BIT], 1'b0)
        rd(OFS_SD); `CHK(rq[SD_SHUT_BIT], 1'b1)
        `CHK(shutdown_irq_flag, 1'b1)
        `CHK(osc_keep_alive, cs)
        `CHK(wave_out, 4'h5)
        wr(OFS_SD, 8'h10); rise(); `CHK(wave_out, 4'ha)
    endtask

    // Falling input to turn-on of B, counted in clock edges
    task automatic meas(input int d, input int t);
        int k;
        k = 0;
        data_in <= 1'b0;
        do begin @(posedge pclk); k++; end while (wave_out.out_b !== 1'b1 && k < 600);
        `CHK(in_win(k, d, t), 1'b1)
        `CHK(wave_out.out_a, 1'b0)
        data_in <= 1'b1;
        cyc(8);
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; data_in = 1'b0; trip = 1'b0; flt = '1;
        fail_count = 0; cmp_count = 0;
        void'($urandom(66));
        cyc(4);
        presetn <= 1'b1;
        for (int a = 0; a <= 20; a += 4) begin rd(8'(a)); `CHK(rq, 32'h0) end
        rd(8'h18); `CHK(re, 1'b1) `CHK(rq, 32'h0)
        for (int m = 0; m < 6; m++) begin wr(OFS_CTRL, 8'(m)); rd(OFS_CTRL); `CHK(rq[2:0], 3'(m)) end
        $display("test registers done");
        dl = '{0, 63};
        repeat (4) dl.push_back($urandom_range(1, 62));
        foreach (dl[j]) begin setup(6'(dl[j]), 1'b0, MODE_HALF); meas(dl[j], 1); end
        setup(6'h03, 1'b1, MODE_HALF); meas(3, OSC_DIV_INT);
        $display("test dead band done");
        setup(6'd20, 1'b0, MODE_HALF);
        data_in <= 1'b0; cyc(10); data_in <= 1'b1; sb = 1'b0;
        repeat (40) begin @(posedge pclk); sb = sb | wave_out.out_b; end
        `CHK(sb, 1'b0)
        $display("test suppress done");
        setup(6'd2, 1'b0, MODE_HALF);
        wr(OFS_DBF, 8'd30); rd(OFS_DBF); `CHK(rq[5:0], 6'd30)
        meas(2, 1);
        wr(OFS_CTRL, 8'hc4); rd(OFS_CTRL); `CHK(rq[CTRL_LD_BIT], 1'b1)
        meas(2, 1);
        rd(OFS_CTRL); `CHK(rq[CTRL_LD_BIT], 1'b0)
        meas(30, 1);
        $display("test load done");
        setup(6'd4, 1'b0, MODE_HALF); wr(OFS_CTRL, 8'h83); rise();
        `CHK(wave_out, 4'h6)
        wr(OFS_CTRL, 8'h82); data_in <= 1'b0; cyc(6); data_in <= 1'b1; k2 = 0;
        do begin @(posedge pclk); k2++; end while (wave_out.out_d !== 1'b1 && k2 < 600);
        `CHK(in_win(k2, 4, 1), 1'b1)
        `CHK(wave_out.out_a, 1'b1)
        $display("test forward turn done");
        for (int i = 0; i < SRC_W; i++) begin
            setup(6'h01, 1'b0, MODE_HALF);
            wr(OFS_SRC, 8'h3f ^ (8'h01 << i)); fset(i, 1'b0); cyc(4);
            `CHK(wave_out, 4'ha)
            fset(i, 1'b1); wr(OFS_SRC, 8'h01 << i); wr(OFS_STAT, 8'h02); cyc(1);
            `CHK(shutdown_irq_flag, 1'b0)
            fset(i, 1'b0); @(negedge pclk); `CHK(wave_out, 4'h5)
            cyc(3); rd(OFS_SD); `CHK(rq[SD_SHUT_BIT], 1'b1)
            `CHK(shutdown_irq_flag, 1'b1)
            wr(OFS_SD, 8'h10); rd(OFS_SD); `CHK(rq[SD_SHUT_BIT], 1'b1)
            fset(i, 1'b1); cyc(4); `CHK(wave_out, 4'h5)
            wr(OFS_SD, 8'h10); rd(OFS_SD); `CHK(rq[SD_SHUT_BIT], 1'b0)
            rise(); `CHK(wave_out, 4'ha)
        end
        $display("test faults done");
        setup(6'h01, 1'b0, MODE_HALF);
        wr(OFS_SD, 8'h50); wr(OFS_SRC, 8'h02); fset(1, 1'b0); cyc(4);
        rd(OFS_SD); `CHK(rq[SD_SHUT_BIT], 1'b1)
        fset(1, 1'b1); cyc(6); rd(OFS_SD); `CHK(rq[SD_SHUT_BIT], 1'b0)
        `CHK(wave_out, 4'h5)
        rise(); `CHK(wave_out, 4'ha)
        $display("test auto restart done");
        wr(OFS_SD, 8'h90); cyc(20); `CHK(wave_out, 4'h5)
        rd(OFS_SD); `CHK(rq[SD_SHUT_BIT], 1'b1)
        $display("test software shutdown done");
        summarize();
    end
endmodule // dasw_core_tb_top
